// *** ptr_timer.v ***
// Purpose: programmable down-counting protocol timer with Avalon-MM registers
// Assumes: carrier_tick is a one-cycle enable at the carrier rate; inputs synchronous
// Notes: registers answer with one wait state; read data stands in the cycle after it, when waitrequest drops; irq is a level
`timescale 1ns/1ps
`include "ptr_map.vh"
module ptr_timer (
    input wire clk,
    input wire reset_n,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire carrier_tick,
    input wire tx_end,
    input wire rx_fifth_bit,
    input wire multi_frame_receive,
    input wire mux_input_pin,
    input wire aux_pin_one,
    output reg timer_running,
    output wire irq
);
    // ==========================================
    // bus slave
    reg ack_q;
    reg [7:0] mode_q;
    reg [7:0] prescale_low_byte;
    reg [7:0] reload_high_byte;
    reg [7:0] reload_low_byte;
    reg [15:0] count_q;
    reg [1:0] irq_status_q;
    reg [1:0] irq_mask_q;
    reg [1:0] irq_set;
    wire req;
    wire wr_go;
    wire rd_go;
    wire sw_start;
    wire sw_stop;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_go = avs_write & ack_q & avs_byteenable[0];
    // read data captured in the wait cycle, so it stands when waitrequest drops
    assign rd_go = avs_read & ~ack_q;

    function hit;
        input [7:0] idx;
        begin
            hit = (avs_address == idx);
        end
    endfunction

    assign sw_start = wr_go && hit(`PTR_IDX_CONTROL) && avs_writedata[`PTR_CTRL_START_BIT];
    assign sw_stop = wr_go && hit(`PTR_IDX_CONTROL) && avs_writedata[`PTR_CTRL_STOP_BIT];

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= `PTR_RST_BYTE;
            prescale_low_byte <= `PTR_RST_BYTE;
            reload_high_byte <= `PTR_RST_BYTE;
            reload_low_byte <= `PTR_RST_BYTE;
            irq_mask_q <= `PTR_RST_IRQ;
        end else if (wr_go) begin
            if (hit(`PTR_IDX_MODE)) begin
                mode_q <= avs_writedata[7:0];
            end else if (hit(`PTR_IDX_PRESC_LO)) begin
                prescale_low_byte <= avs_writedata[7:0];
            end else if (hit(`PTR_IDX_RELOAD_HI)) begin
                reload_high_byte <= avs_writedata[7:0];
            end else if (hit(`PTR_IDX_RELOAD_LO)) begin
                reload_low_byte <= avs_writedata[7:0];
            end else if (hit(`PTR_IDX_IRQ_MASK)) begin
                irq_mask_q <= avs_writedata[1:0];
            end
        end
    end

    // unmapped addresses read zero
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata <= 32'h0000_0000;
            if (hit(`PTR_IDX_MODE)) begin
                avs_readdata[7:0] <= mode_q;
            end else if (hit(`PTR_IDX_PRESC_LO)) begin
                avs_readdata[7:0] <= prescale_low_byte;
            end else if (hit(`PTR_IDX_RELOAD_HI)) begin
                avs_readdata[7:0] <= reload_high_byte;
            end else if (hit(`PTR_IDX_RELOAD_LO)) begin
                avs_readdata[7:0] <= reload_low_byte;
            end else if (hit(`PTR_IDX_COUNT_HI)) begin
                avs_readdata[7:0] <= count_q[15:8];
            end else if (hit(`PTR_IDX_COUNT_LO)) begin
                avs_readdata[7:0] <= count_q[7:0];
            end else if (hit(`PTR_IDX_IRQ_STATUS)) begin
                avs_readdata[1:0] <= irq_status_q;
            end else if (hit(`PTR_IDX_IRQ_MASK)) begin
                avs_readdata[1:0] <= irq_mask_q;
            end else if (hit(`PTR_IDX_RUN_STATUS)) begin
                avs_readdata[0] <= timer_running;
            end
        end
    end

    // ==========================================
    // mode decode
    wire auto_start_after_tx;
    wire auto_reload_enable;
    wire [1:0] gate_source_select;
    wire [11:0] prescale_value;
    wire [15:0] reload_value;
    reg gate_open;

    assign auto_start_after_tx = mode_q[`PTR_MODE_AUTO_BIT];
    assign auto_reload_enable = mode_q[`PTR_MODE_RESTART_BIT];
    assign gate_source_select = mode_q[`PTR_MODE_GATE_HI:`PTR_MODE_GATE_LO];
    assign prescale_value = {mode_q[`PTR_MODE_PRESC_HI:`PTR_MODE_PRESC_LO],
                             prescale_low_byte};
    assign reload_value = {reload_high_byte, reload_low_byte};

    always @* begin
        case (gate_source_select)
            `PTR_GATE_NONE: gate_open = 1'b1;
            `PTR_GATE_MUX_IN: gate_open = mux_input_pin;
            `PTR_GATE_AUX_ONE: gate_open = aux_pin_one;
            default: gate_open = 1'b1;
        endcase
    end

    // ==========================================
    // counter
    wire start_event;
    wire stop_event;
    wire tick;

    assign start_event = sw_start | (auto_start_after_tx & tx_end);
    assign stop_event = sw_stop |
        (auto_start_after_tx & ~multi_frame_receive & rx_fifth_bit);

    ptr_prescaler u_presc (
        .clk(clk),
        .reset_n(reset_n),
        .restart(start_event),
        .enable(timer_running & gate_open),
        .carrier_tick(carrier_tick),
        .prescale_value(prescale_value),
        .tick(tick)
    );

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 16'h0000;
            timer_running <= 1'b0;
        end else begin
            if (start_event) begin
                count_q <= reload_value;
                timer_running <= 1'b1;
            end else if (stop_event) begin
                timer_running <= 1'b0;
            end else if (timer_running && tick) begin
                if (count_q == 16'h0000) begin
                    if (auto_reload_enable) begin
                        count_q <= reload_value;
                    end else begin
                        timer_running <= 1'b0;
                    end
                end else begin
                    count_q <= count_q - 16'h0001;
                end
            end
        end
    end

    // ==========================================
    // interrupts: expiry at zero; set wins over write-one-to-clear
    always @* begin
        irq_set = 2'b00;
        if (timer_running && tick && !start_event && !stop_event && count_q == 16'h0000) begin
            if (auto_reload_enable) begin
                irq_set[`PTR_IRQ_RELOADED_BIT] = 1'b1;
            end else begin
                irq_set[`PTR_IRQ_EXPIRED_BIT] = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_q <= `PTR_RST_IRQ;
        end else begin
            if (wr_go && hit(`PTR_IDX_IRQ_STATUS)) begin
                irq_status_q <= (irq_status_q & ~avs_writedata[1:0]) | irq_set;
            end else begin
                irq_status_q <= irq_status_q | irq_set;
            end
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);
endmodule // ptr_timer

// *** ptr_map.vh ***
// Purpose: register offsets, field positions, reset values for the protocol timer
// Assumes: byte registers, one per aligned 32-bit Avalon word
// Notes: byte address is four times the register index
`ifndef PTR_MAP_VH
`define PTR_MAP_VH
// ==========================================
// register indices
`define PTR_IDX_MODE 8'h2A
`define PTR_IDX_PRESC_LO 8'h2B
`define PTR_IDX_RELOAD_HI 8'h2C
`define PTR_IDX_RELOAD_LO 8'h2D
`define PTR_IDX_COUNT_HI 8'h2E
`define PTR_IDX_COUNT_LO 8'h2F
`define PTR_IDX_CONTROL 8'h40
`define PTR_IDX_IRQ_STATUS 8'h41
`define PTR_IDX_IRQ_MASK 8'h42
`define PTR_IDX_RUN_STATUS 8'h43
// ==========================================
// mode register fields
`define PTR_MODE_AUTO_BIT 7
`define PTR_MODE_GATE_HI 6
`define PTR_MODE_GATE_LO 5
`define PTR_MODE_RESTART_BIT 4
`define PTR_MODE_PRESC_HI 3
`define PTR_MODE_PRESC_LO 0
// gate select codes
`define PTR_GATE_NONE 2'b00
`define PTR_GATE_MUX_IN 2'b01
`define PTR_GATE_AUX_ONE 2'b10
// control register bits (write-only strobes)
`define PTR_CTRL_START_BIT 0
`define PTR_CTRL_STOP_BIT 1
// irq status bits
`define PTR_IRQ_EXPIRED_BIT 0
`define PTR_IRQ_RELOADED_BIT 1
// ==========================================
// reset values
`define PTR_RST_BYTE 8'h00
`define PTR_RST_IRQ 2'b00
`endif

// *** ptr_prescaler.v ***
// Purpose: divides the carrier-rate clock enable into the timer tick
// Assumes: carrier_tick marks one carrier period
// Notes: tick every prescale_value+1 carrier periods while enabled
`timescale 1ns/1ps
module ptr_prescaler (
    input wire clk,
    input wire reset_n,
    input wire restart,
    input wire enable,
    input wire carrier_tick,
    input wire [11:0] prescale_value,
    output reg tick
);
    reg [11:0] div_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 12'h000;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (restart) begin
                div_q <= prescale_value;
            end else if (enable && carrier_tick) begin
                if (div_q == 12'h000) begin
                    div_q <= prescale_value;
                    tick <= 1'b1;
                end else begin
                    div_q <= div_q - 12'h001;
                end
            end
        end
    end
endmodule // ptr_prescaler

// *** ptr_timer_asserts.sv ***
// Purpose: port-level checks for ptr_timer
// Assumes: one clock domain, async active-low reset
// Notes: bound to every ptr_timer instance
`timescale 1ns/1ps
module ptr_timer_asserts (
    input wire clk,
    input wire reset_n,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire carrier_tick,
    input wire tx_end,
    input wire rx_fifth_bit,
    input wire timer_running,
    input wire irq
);
    // ==========================================
    // recent causes of run and flag changes
    wire req = avs_read | avs_write;
    reg [3:0] go_q;
    reg [3:0] why_q;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            go_q <= 4'h0;
            why_q <= 4'h0;
        end else begin
            go_q <= {go_q[2:0], tx_end | avs_write};
            why_q <= {why_q[2:0], carrier_tick | avs_write | rx_fifth_bit};
        end
    end
    // ==========================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_wait_first_cycle: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait state on new request");
    a_wait_one_only: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state too long");
    a_wait_idle_low: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_data_holds: assert property (!$stable(avs_readdata) |-> $past(avs_read && avs_waitrequest))
        else $error("readdata changed without read");
    a_upper_zero: assert property (avs_readdata[31:8] == 24'h00_0000)
        else $error("readdata upper bits set");
    a_start_cause: assert property ($rose(timer_running) |-> |go_q)
        else $error("timer started without start event");
    a_stop_cause: assert property ($fell(timer_running) |-> |why_q)
        else $error("timer stopped without cause");
    a_irq_cause: assert property ($rose(irq) |-> |why_q)
        else $error("irq rose without cause");
    c_start: cover property ($rose(timer_running));
    c_stop: cover property ($fell(timer_running));
    c_irq: cover property ($rose(irq));
endmodule // ptr_timer_asserts
bind ptr_timer ptr_timer_asserts ptr_timer_asserts_i (.clk(clk), .reset_n(reset_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .carrier_tick(carrier_tick), .tx_end(tx_end),
    .rx_fifth_bit(rx_fifth_bit), .timer_running(timer_running), .irq(irq));

// *** ptr_timer_tb_top.sv ***
// Purpose: self-checking bench for ptr_timer
// Assumes: bench makes carrier_tick; start restarts the prescaler
// Notes: read data compared at the edge where waitrequest is sampled low
`timescale 1ns/1ps
`include "ptr_map.vh"
module ptr_timer_tb_top;
    reg clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, carrier_tick = 0, tx_end = 0;
    reg rx_fifth_bit = 0, multi_frame_receive = 0, mux_input_pin = 0, aux_pin_one = 0;
    reg [7:0] avs_address = 8'h00;
    reg [31:0] avs_writedata = 32'h0000_0000;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, timer_running, irq;
    integer miscompares = 0, num_checks = 0, i;
    reg [3:0] avs_byteenable = 4'h1;
    reg [31:0] exp_q[$];
    reg [31:0] rnd;
    reg [15:0] rl, cnt;
    always #12.5 clk = ~clk;
    ptr_timer ptr_timer_i (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .carrier_tick(carrier_tick), .tx_end(tx_end), .rx_fifth_bit(rx_fifth_bit),
        .multi_frame_receive(multi_frame_receive), .mux_input_pin(mux_input_pin),
        .aux_pin_one(aux_pin_one), .timer_running(timer_running), .irq(irq));
    // ==========================================
    // checking and bus tasks
    task tally_and_finish;
        miscompares += exp_q.size();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task cmp_read(input [31:0] e, input [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch readdata expected %h seen %h", e, g);
        end
    endtask
    task cmp_irq(input e, input g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch irq expected %b seen %b", e, g);
        end
    endtask
    task cmp_run(input e, input g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch timer_running expected %b seen %b", e, g);
        end
    endtask
    // request held until the rising edge that samples waitrequest low
    task bus(input rw, input [7:0] a, input [7:0] d);
        integer n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= rw;
        avs_read <= !rw;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            tally_and_finish;
        end else begin
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge clk);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input [7:0] a, input [7:0] e);
        exp_q.push_back({24'h00_0000, e});
        bus(1'b0, a, 8'h00);
    endtask
    // n carrier periods, one-cycle tick every third clock
    task pulse(input integer n);
        repeat (n) begin
            carrier_tick <= 1'b1;
            @(posedge clk);
            carrier_tick <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    // read data stands at the edge where waitrequest is sampled low
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            cmp_read(exp_q.pop_front(), avs_readdata);
    end
    // ==========================================
    // scenarios
    initial begin
        i = $urandom(33);
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 3; i++)
            rd(`PTR_IDX_PRESC_LO + i[7:0], 8'h00);
        rd(8'h30, 8'h00);
        rnd = $urandom;
        rl = rnd[15:0] | 16'h0100;
        wr(`PTR_IDX_PRESC_LO, 8'h02);
        wr(`PTR_IDX_MODE, 8'h01);
        wr(`PTR_IDX_RELOAD_HI, rl[15:8]);
        wr(`PTR_IDX_RELOAD_LO, rl[7:0]);
        rd(`PTR_IDX_PRESC_LO, 8'h02);
        rd(`PTR_IDX_RELOAD_LO, rl[7:0]);
        avs_byteenable <= 4'h0;
        wr(`PTR_IDX_PRESC_LO, 8'hFF);
        avs_byteenable <= 4'h1;
        rd(`PTR_IDX_PRESC_LO, 8'h02);
        wr(`PTR_IDX_CONTROL, 8'h01);
        pulse(3 * 259);
        cnt = rl - 16'h0003;
        wr(`PTR_IDX_RELOAD_LO, ~rl[7:0]);
        rd(`PTR_IDX_COUNT_HI, cnt[15:8]);
        rd(`PTR_IDX_COUNT_LO, cnt[7:0]);
        wr(`PTR_IDX_CONTROL, 8'h01);
        rd(`PTR_IDX_COUNT_LO, ~rl[7:0]);
        wr(`PTR_IDX_PRESC_LO, 8'h00);
        wr(`PTR_IDX_RELOAD_HI, 8'h00);
        wr(`PTR_IDX_RELOAD_LO, 8'h02);
        for (i = 0; i < 2; i++) begin
            wr(`PTR_IDX_IRQ_MASK, {6'h00, i[0], 1'b0});
            wr(`PTR_IDX_MODE, {3'h0, i[0], 4'h0});
            wr(`PTR_IDX_CONTROL, 8'h01);
            pulse(3);
            rd(`PTR_IDX_IRQ_STATUS, i[0] ? 8'h02 : 8'h01);
            rd(`PTR_IDX_RUN_STATUS, i[7:0]);
            rd(`PTR_IDX_COUNT_LO, i[0] ? 8'h02 : 8'h00);
            cmp_run(i[0], timer_running);
            cmp_irq(i[0], irq);
            wr(`PTR_IDX_IRQ_STATUS, 8'h03);
            cmp_irq(1'b0, irq);
        end
        wr(`PTR_IDX_CONTROL, 8'h02);
        wr(`PTR_IDX_MODE, 8'h80);
        for (i = 0; i < 2; i++) begin
            multi_frame_receive <= i[0];
            tx_end <= 1'b1;
            @(posedge clk);
            tx_end <= 1'b0;
            rd(`PTR_IDX_RUN_STATUS, 8'h01);
            rx_fifth_bit <= 1'b1;
            @(posedge clk);
            rx_fifth_bit <= 1'b0;
            rd(`PTR_IDX_RUN_STATUS, i[7:0]);
            cmp_run(i[0], timer_running);
        end
        wr(`PTR_IDX_RELOAD_LO, 8'h0A);
        for (i = 1; i < 3; i++) begin
            wr(`PTR_IDX_MODE, {1'b0, i[1:0], 5'h00});
            wr(`PTR_IDX_CONTROL, 8'h01);
            pulse(3);
            rd(`PTR_IDX_COUNT_LO, 8'h0A);
            mux_input_pin <= i[0];
            aux_pin_one <= i[1];
            pulse(3);
            rd(`PTR_IDX_COUNT_LO, 8'h07);
            mux_input_pin <= 1'b0;
            aux_pin_one <= 1'b0;
        end
        repeat (3) @(posedge clk);
        tally_and_finish;
    end
endmodule // ptr_timer_tb_top
